// ---- inc/cssx_pkg.sv ----
/*
 Package for the core status and external memory control block: register
 addresses, field positions, reset values and timing counts.
 Assumes a CPU clock enable is not needed; one CPU clock period is one clk.
*/
package cssx_pkg;
   // ==================================================================
   // Register addresses
   localparam logic [7:0] CSSX_AUX_ADDR = 8'h8E;
   localparam logic [7:0] CSSX_PSW_ADDR = 8'hD0;
   // ==================================================================
   // Reset values
   localparam logic [7:0] CSSX_AUX_RST = 8'h0D;
   localparam logic [7:0] CSSX_PSW_RST = 8'h00;
   // ==================================================================
   // Status word fields
   localparam int CSSX_PSW_CY = 7;
   localparam int CSSX_PSW_AC = 6;
   localparam int CSSX_PSW_F0 = 5;
   localparam int CSSX_PSW_RS_LO = 3;
   localparam int CSSX_PSW_OV = 2;
   localparam int CSSX_PSW_F1 = 1;
   localparam int CSSX_PSW_P = 0;
   // ==================================================================
   // Aux control fields
   localparam int CSSX_AUX_RSV = 7;
   localparam int CSSX_AUX_WIDE = 6;
   localparam int CSSX_AUX_STR = 5;
   localparam int CSSX_AUX_HSUP = 4;
   localparam int CSSX_AUX_XRS_LO = 2;
   localparam int CSSX_AUX_OFFC = 1;
   localparam int CSSX_AUX_ALEG = 0;
   // ==================================================================
   // Timing counts in CPU clock periods
   localparam logic [3:0] CSSX_STROBE_SHORT = 4'h3;
   localparam logic [3:0] CSSX_STROBE_LONG = 4'hF;
   localparam logic [3:0] CSSX_CYCLE_LEN = 4'h6;
   localparam logic [3:0] CSSX_STD_OSC_PER = 4'hC;
   localparam logic [3:0] CSSX_X2_OSC_PER = 4'h6;
   localparam logic [1:0] CSSX_ALE_DIV = 2'h3;
   // Strobe starts at this cycle position within the access
   localparam logic [3:0] CSSX_STROBE_START = 4'h2;
endpackage : cssx_pkg

// ---- design/cssx_core.sv ----
/*
 Status word and aux control registers with the external data move
 sequencer they steer (strobe width, latch pulse, upper port, RAM target).
 Assumes the CPU supplies ALU results and one move request at a time on clk.
*/
`timescale 1ns/1ps

module cssx_core
   import cssx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Special register access
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_rvalid,
   // ALU flag updates
   input wire logic [7:0] acc,
   input wire logic alu_cy_we,
   input wire logic alu_cy,
   input wire logic alu_ac_we,
   input wire logic alu_ac,
   input wire logic alu_ov_we,
   input wire logic alu_ov,
   // External move request
   input wire logic mv_start,
   input wire logic mv_write,
   input wire logic mv_use_ptr,
   input wire logic [15:0] mv_addr,
   input wire logic [7:0] sfr_upper,
   output logic mv_busy,
   // Derived control
   output logic [4:0] bank_base,
   output logic [11:0] ram_limit,
   output logic target_offchip,
   output logic wide_xfer,
   // Bus pins
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic addr_latch,
   output logic [7:0] upper_addr_port,
   output logic upper_addr_drive
);
   // ==================================================================
   // State
   typedef enum logic [1:0] {
      CSSX_IDLE = 2'b01,
      CSSX_MOVE = 2'b10
   } cssx_state_t;

   typedef struct packed {
      cssx_state_t st;
      logic [7:0] program_status_word;
      logic [7:0] aux;
      logic [4:0] cnt; // Five bits: a stretched move runs to 17
      logic [4:0] len;
      logic wr;
      logic [1:0] ale_div;
      logic [7:0] rdata;
      logic rvalid;
      logic [4:0] bank;
      logic [11:0] limit;
      logic offc;
      logic wide;
      logic rd_n;
      logic wr_n;
      logic ale;
      logic [7:0] upper;
      logic udrv;
   } cssx_regs_t;

   cssx_regs_t s_reg;
   cssx_regs_t s_next;

   // Top of internal expanded RAM for a size code
   function automatic logic [11:0] cssx_ram_top(input logic [1:0] code);
      unique case (code)
         2'h0: cssx_ram_top = 12'h0FF;
         2'h1: cssx_ram_top = 12'h1FF;
         2'h2: cssx_ram_top = 12'h3FF;
         default: cssx_ram_top = 12'h7FF;
      endcase
   endfunction

   // Even parity over the accumulator; used for the stored and the read bit
   function automatic logic cssx_parity(input logic [7:0] val);
      cssx_parity = ^val;
   endfunction

   // Move timeline, counted in positions after the start edge:
   //   position 0   latch pulse high, upper port driven, busy high
   //   position 1   latch pulse low, strobes still high (address setup)
   //   positions 2+ strobe low for 3 periods, or 15 when stretched
   //   last         strobe high again, then back to idle (both on the same edge when stretched)
   // An unstretched move spans six periods. A stretched one is made
   // longer (17 periods) rather than squeezing the strobe, so a slow
   // device keeps its full access window; the cost is that busy stays
   // high for the whole stretched cycle.

   // Strobe window test for a cycle position of a move.
   // Five bits are needed: the stretched window ends at position 17,
   // which a four-bit count would wrap back to 1.
   function automatic logic cssx_strobe_on(input logic [4:0] pos, input logic stretch);
      logic [4:0] stop;
      stop = 5'(CSSX_STROBE_START) + (stretch ? 5'(CSSX_STROBE_LONG) : 5'(CSSX_STROBE_SHORT));
      cssx_strobe_on = pos >= 5'(CSSX_STROBE_START) && pos < stop;
   endfunction

   // Move length in periods: six, or strobe start plus 15 when stretched
   function automatic logic [4:0] cssx_move_len(input logic stretch);
      if (stretch) begin
         cssx_move_len = 5'(CSSX_STROBE_START) + 5'(CSSX_STROBE_LONG);
      end else begin
         cssx_move_len = 5'(CSSX_CYCLE_LEN);
      end
   endfunction

   // ==================================================================
   // Next state
   always_comb begin
      logic [7:0] aux_w;
      logic [11:0] top;
      logic in_ram;
      logic strobe_on;
      logic [4:0] step;
      aux_w = 8'h00;
      step = 5'h00;
      top = 12'h000;
      in_ram = 1'b0;
      strobe_on = 1'b0;
      s_next = s_reg;
      s_next.rvalid = 1'b0;

      // Register writes; aux bit 7 stored as zero whatever software writes to it
      if (sfr_wr && sfr_addr == CSSX_PSW_ADDR) begin
         s_next.program_status_word = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == CSSX_AUX_ADDR) begin
         aux_w = sfr_wdata;
         aux_w[CSSX_AUX_RSV] = 1'b0;
         s_next.aux = aux_w;
      end

      // Hardware flag updates win over a same-cycle software write
      if (alu_cy_we) begin
         s_next.program_status_word[CSSX_PSW_CY] = alu_cy;
      end
      if (alu_ac_we) begin
         s_next.program_status_word[CSSX_PSW_AC] = alu_ac;
      end
      if (alu_ov_we) begin
         s_next.program_status_word[CSSX_PSW_OV] = alu_ov;
      end
      // Parity follows the accumulator every cycle, whatever was written
      s_next.program_status_word[CSSX_PSW_P] = cssx_parity(acc);

      // Read path; unmapped addresses return zero
      if (sfr_rd) begin
         s_next.rvalid = 1'b1;
         if (sfr_addr == CSSX_PSW_ADDR) begin
            // Live parity, so a read right after an accumulator change is exact
            s_next.rdata = {s_reg.program_status_word[7:1], cssx_parity(acc)};
         end else if (sfr_addr == CSSX_AUX_ADDR) begin
            s_next.rdata = s_reg.aux;
         end else begin
            s_next.rdata = 8'h00;
         end
      end

      // Derived decode, from the settled register values
      s_next.bank = {s_reg.program_status_word[CSSX_PSW_RS_LO +: 2], 3'h0};
      top = cssx_ram_top(s_reg.aux[CSSX_AUX_XRS_LO +: 2]);
      s_next.limit = top;
      s_next.wide = s_reg.aux[CSSX_AUX_WIDE];

      // Free-running latch divider by three
      if (s_reg.ale_div == CSSX_ALE_DIV - 2'h1) begin
         s_next.ale_div = 2'h0;
      end else begin
         s_next.ale_div = s_reg.ale_div + 2'h1;
      end

      // Move sequencer
      unique case (s_reg.st)
         CSSX_IDLE: begin
            s_next.rd_n = 1'b1;
            s_next.wr_n = 1'b1;
            s_next.udrv = 1'b0;
            s_next.ale = !s_reg.aux[CSSX_AUX_ALEG] && s_reg.ale_div == 2'h0;
            if (mv_start) begin
               in_ram = mv_addr[15:12] == 4'h0 && mv_addr[11:0] <= top;
               s_next.offc = s_reg.aux[CSSX_AUX_OFFC] || !in_ram;
               s_next.st = CSSX_MOVE;
               s_next.cnt = 5'h00;
               s_next.wr = mv_write;
               // Stretched strobe extends the cycle past six periods
               s_next.len = cssx_move_len(s_reg.aux[CSSX_AUX_STR]);
               s_next.ale = 1'b1;
               if (mv_use_ptr && !s_reg.aux[CSSX_AUX_HSUP]) begin
                  s_next.upper = mv_addr[15:8];
               end else begin
                  s_next.upper = sfr_upper;
               end
               s_next.udrv = 1'b1;
            end
         end
         CSSX_MOVE: begin
            step = s_reg.cnt + 5'h01;
            s_next.cnt = step;
            s_next.ale = 1'b0;
            strobe_on = cssx_strobe_on(step, s_reg.aux[CSSX_AUX_STR]);
            s_next.rd_n = !(strobe_on && !s_reg.wr);
            s_next.wr_n = !(strobe_on && s_reg.wr);
            // Leave on the last position; strobes already high, or rising on this same edge when stretched
            if (step == s_reg.len) begin
               s_next.st = CSSX_IDLE;
            end
         end
         default: begin
            s_next.st = CSSX_IDLE;
         end
      endcase
   end

   // ==================================================================
   // Registers
   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg.st <= CSSX_IDLE;
         s_reg.program_status_word <= CSSX_PSW_RST;
         s_reg.aux <= CSSX_AUX_RST;
         s_reg.cnt <= 5'h00;
         s_reg.len <= 5'(CSSX_CYCLE_LEN);
         s_reg.wr <= 1'b0;
         s_reg.ale_div <= 2'h0;
         s_reg.rdata <= 8'h00;
         s_reg.rvalid <= 1'b0;
         s_reg.bank <= 5'h00;
         s_reg.limit <= 12'h7FF;
         s_reg.offc <= 1'b0;
         s_reg.wide <= 1'b0;
         s_reg.rd_n <= 1'b1;
         s_reg.wr_n <= 1'b1;
         s_reg.ale <= 1'b0;
         s_reg.upper <= 8'h00;
         s_reg.udrv <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==================================================================
   // Outputs straight from flops
   assign sfr_rdata = s_reg.rdata;
   assign sfr_rvalid = s_reg.rvalid;
   assign mv_busy = s_reg.st[1]; // One-hot move bit, a flop output
   assign bank_base = s_reg.bank;
   assign ram_limit = s_reg.limit;
   assign target_offchip = s_reg.offc;
   assign wide_xfer = s_reg.wide;
   assign read_strobe_n = s_reg.rd_n;
   assign write_strobe_n = s_reg.wr_n;
   assign addr_latch = s_reg.ale;
   assign upper_addr_port = s_reg.upper;
   assign upper_addr_drive = s_reg.udrv;
endmodule // cssx_core

// ---- dv/cssx_core_assertions.sv ----
/* Checker for cssx_core port timing: register reads, move sequencing.
 Assumes it is bound to every cssx_core instance and sees its ports only. */
`timescale 1ns/1ps
module cssx_core_chk
   import cssx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register side
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] acc,
   // Move side and pins
   input wire logic mv_start,
   input wire logic mv_busy,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic addr_latch,
   input wire logic upper_addr_drive
);
   // ==================================================================
   // Properties, one clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_par; sfr_rd && sfr_addr == CSSX_PSW_ADDR |=> sfr_rdata[0] == ^$past(acc); endproperty
   a_par: assert property (p_par) else $error("parity bit wrong");
   property p_go; mv_start && !mv_busy |=> mv_busy && addr_latch && upper_addr_drive; endproperty
   a_go: assert property (p_go) else $error("move start wrong");
   property p_excl; read_strobe_n || write_strobe_n; endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_in; !(read_strobe_n && write_strobe_n) |-> mv_busy; endproperty
   a_in: assert property (p_in) else $error("strobe outside move");
   property p_len; $rose(mv_busy) |-> mv_busy [*6] ##[1:12] !mv_busy; endproperty
   a_len: assert property (p_len) else $error("move length wrong");
   // Strobe waits one period after the latch pulse, address setup for slow latches
   property p_stb;
      $rose(mv_busy) |-> ##1 (read_strobe_n && write_strobe_n) ##1 !(read_strobe_n && write_strobe_n);
   endproperty
   a_stb: assert property (p_stb) else $error("strobe start wrong");
   property p_min; $fell(read_strobe_n && write_strobe_n) |-> !(read_strobe_n && write_strobe_n) [*3]; endproperty
   a_min: assert property (p_min) else $error("strobe too short");
   property p_ale; $rose(mv_busy) |-> addr_latch ##1 !addr_latch; endproperty
   a_ale: assert property (p_ale) else $error("latch pulse wrong");
   // Main scenarios
   c_rd: cover property ($fell(read_strobe_n));
   c_wr: cover property ($fell(write_strobe_n));
   c_go: cover property (mv_start && !mv_busy);
endmodule // cssx_core_chk
bind cssx_core cssx_core_chk i_chk (.clk, .srst, .sfr_rd, .sfr_addr, .sfr_rdata, .acc, .mv_start,
   .mv_busy, .read_strobe_n, .write_strobe_n, .addr_latch, .upper_addr_drive);

// ---- dv/cssx_xmem_model.sv ----
/* External data memory seen from its strobes: measures strobe widths.
 Assumes strobes are active low and one CPU period is one clk. */
`timescale 1ns/1ps
module cssx_xmem_model (
   // Bus pins
   input wire logic clk,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   // Last measured widths
   output logic [4:0] rd_len,
   output logic [4:0] wr_len
);
   logic [4:0] rd_cnt = 5'h00;
   logic [4:0] wr_cnt = 5'h00;
   // Width latched on release; five bits hold the stretched count
   always @(posedge clk) begin
      rd_cnt <= read_strobe_n ? 5'h00 : rd_cnt + 5'h01;
      wr_cnt <= write_strobe_n ? 5'h00 : wr_cnt + 5'h01;
      if (read_strobe_n && rd_cnt != 5'h00) rd_len <= rd_cnt;
      if (write_strobe_n && wr_cnt != 5'h00) wr_len <= wr_cnt;
   end
endmodule // cssx_xmem_model

// ---- dv/tb_core_status_and_xmem_control.sv ----
/* Testbench for cssx_core: reset values, then register table rows, flags and moves.
 Assumes cssx_pkg and the memory model are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_core_status_and_xmem_control;
   import cssx_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] acc; logic [7:0] e;} cssx_row_t;
   logic clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, mv_start = 0, mv_write = 0, mv_use_ptr = 1;
   logic alu_cy_we = 0, alu_cy = 1, alu_ac_we = 0, alu_ac = 1, alu_ov_we = 0, alu_ov = 1;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, acc = 0, sfr_upper = 8'h5A, sfr_rdata, rd, up;
   logic [15:0] mv_addr = 0;
   logic [11:0] ram_limit;
   logic [4:0] bank_base, rd_len, wr_len;
   logic [7:0] upper_addr_port;
   logic mv_busy, target_offchip, wide_xfer, read_strobe_n, write_strobe_n, tgt;
   logic addr_latch, upper_addr_drive, sfr_rvalid;
   int miscompares = 0, n_tests = 0, cyc = 0, k;
   // Status rows, then every RAM size code, then an unmapped place
   cssx_row_t rows [8] = '{'{CSSX_PSW_ADDR, 8'h7E, 8'h01, 8'h7F}, '{CSSX_PSW_ADDR, 8'h18, 8'h03, 8'h18},
      '{CSSX_PSW_ADDR, 8'h08, 8'h07, 8'h09}, '{CSSX_AUX_ADDR, 8'h40, 8'h00, 8'h40},
      '{CSSX_AUX_ADDR, 8'h24, 8'h00, 8'h24}, '{CSSX_AUX_ADDR, 8'h18, 8'h00, 8'h18},
      '{CSSX_AUX_ADDR, 8'h0E, 8'h00, 8'h0E}, '{8'h55, 8'hAA, 8'h00, 8'h00}};
   always #2 clk = ~clk;
   cssx_core i_dut (.clk, .srst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_rvalid,
      .acc, .alu_cy_we, .alu_cy, .alu_ac_we, .alu_ac, .alu_ov_we, .alu_ov, .mv_start, .mv_write,
      .mv_use_ptr, .mv_addr, .sfr_upper, .mv_busy, .bank_base, .ram_limit, .target_offchip,
      .wide_xfer, .read_strobe_n, .write_strobe_n, .addr_latch, .upper_addr_port, .upper_addr_drive);
   cssx_xmem_model i_mem (.clk, .read_strobe_n, .write_strobe_n, .rd_len, .wr_len);
   // ==================================================================
   // Bus tasks
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      `CHK("rvalid", 1'b1, sfr_rvalid)
      rd = sfr_rdata;
   endtask
   // Upper port and target are looked at in the first move cycle only
   task mv(input logic w, input logic [15:0] a);
      @(posedge clk);
      mv_start <= 1'b1;
      mv_write <= w;
      mv_addr <= a;
      @(posedge clk);
      mv_start <= 1'b0;
      #1;
      up = upper_addr_port;
      tgt = target_offchip;
      for (k = 0; k < 40 && mv_busy !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      repeat (2) @(posedge clk);
   endtask
   task ale_count;
      k = 0;
      repeat (9) @(posedge clk) #1 k += (addr_latch === 1'b1);
   endtask
   task final_report;
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the roughly 115 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         final_report;
      end
   end
   // ==================================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rdr(CSSX_AUX_ADDR);
      `CHK("aux reset", 7'h0D, rd[6:0])
      rdr(CSSX_PSW_ADDR);
      `CHK("status reset", 8'h00, rd)
      foreach (rows[i]) begin
         @(posedge clk) acc <= rows[i].acc;
         wr(rows[i].a, rows[i].d);
         rdr(rows[i].a);
         `CHK("read", rows[i].e, {1'b0, rd[6:0]})
         if (rows[i].a == CSSX_PSW_ADDR) `CHK("bank", {rows[i].d[4:3], 3'h0}, bank_base)
         if (rows[i].a == CSSX_AUX_ADDR) begin
            `CHK("limit", (12'h100 << rows[i].d[3:2]) - 12'h001, ram_limit)
            `CHK("wide", rows[i].d[6], wide_xfer)
         end
      end
      // All three flag updates in one cycle, from cleared flags
      @(posedge clk) {alu_cy_we, alu_ac_we, alu_ov_we} <= 3'h7;
      @(posedge clk) {alu_cy_we, alu_ac_we, alu_ov_we} <= 3'h0;
      rdr(CSSX_PSW_ADDR);
      `CHK("flags", 3'h7, {rd[7], rd[6], rd[2]})
      ale_count;
      `CHK("free latch", 3, k)
      mv(1'b0, 16'hA310);
      `CHK("upper", 8'hA3, up)
      `CHK("offchip", 1'b1, tgt)
      `CHK("read width", 5'h03, rd_len)
      wr(CSSX_AUX_ADDR, 8'h31);
      mv(1'b1, 16'h0010);
      `CHK("upper off", 8'h5A, up)
      `CHK("onchip", 1'b0, tgt)
      `CHK("write width", 5'h0F, wr_len)
      ale_count;
      `CHK("gated latch", 0, k)
      final_report;
   end
endmodule // tb_core_status_and_xmem_control
